// ===== dmcr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "dmcr_consts.vh"
module dmcr_regs
(
  input wire sys_clk,
  input wire soft_reset_pulse,
  input wire ce,
  input wire acc_valid,
  input wire acc_read,
  input wire [6:0] acc_index,
  input wire [7:0] acc_wdata,
  output reg [7:0] acc_rdata_reg,
  output reg acc_rvalid_reg,
  output reg acc_hit_reg,
  output reg acc_rw_bit_reg,
  input wire left_zero_det,
  input wire right_zero_det,
  input wire left_even_det,
  input wire right_even_det,
  input wire left_96_det,
  input wire right_96_det,
  input wire single_channel_mode_data_pin,
  input wire left_stream_pin,
  input wire right_stream_pin,
  output reg left_data_reg,
  output reg right_data_reg,
  output reg left_zero_pin,
  output reg right_zero_pin,
  output reg mute_bpz_reg,
  output wire rolloff_select,
  output wire filter_bypass,
  output wire one_bit_stream_mode,
  output wire single_channel_mode,
  output wire single_channel_mode_channel_pick,
  output wire [1:0] modulator_rate_select,
  output wire [1:0] stream_bit_clock_select,
  output wire [1:0] stream_zero_pattern,
  output wire linear_zero_flag_enable,
  output wire system_reset_pulse
);
  reg [7:0] fzm_reg;
  reg [7:0] mode_reg;
  reg [7:0] zen_reg;
  reg [7:0] fzm_next;
  reg [7:0] mode_next;
  reg [7:0] zen_next;
  reg soft_reset_pulse_trig_next;
  reg [7:0] rdata_next;
  reg hit_next;
  wire int_rst;
  wire stereo_bypass_select;
  wire zero_hold_mute_enable;
  wire wr;
  reg lz_next;
  reg rz_next;
  reg l_sel;
  reg r_sel;

  assign int_rst = soft_reset_pulse | system_reset_pulse;
  assign wr = acc_valid & ~acc_read;
  assign zero_hold_mute_enable = fzm_reg[`DMCR_FZM_HOLD];
  assign rolloff_select = fzm_reg[`DMCR_FZM_ROLL];
  assign stereo_bypass_select = fzm_reg[`DMCR_FZM_STEREO];
  assign modulator_rate_select = one_bit_stream_mode ? `DMCR_RATE_64 :
    mode_reg[`DMCR_MODE_RATE_HI:`DMCR_MODE_RATE_LO];
  assign stream_bit_clock_select = one_bit_stream_mode ?
    mode_reg[`DMCR_MODE_RATE_HI:`DMCR_MODE_RATE_LO] : `DMCR_RATE_64;
  assign single_channel_mode_channel_pick = mode_reg[`DMCR_MODE_PICK];
  assign single_channel_mode = mode_reg[`DMCR_MODE_SINGLE_CHANNEL_MODE];
  assign filter_bypass = mode_reg[`DMCR_MODE_BYPASS];
  assign one_bit_stream_mode = mode_reg[`DMCR_MODE_STREAM];
  assign linear_zero_flag_enable = zen_reg[`DMCR_ZEN_LIN];
  assign stream_zero_pattern = zen_reg[`DMCR_ZEN_PAT_HI:`DMCR_ZEN_PAT_LO];

  // Register writes, reserved bits masked
  always @*
  begin
    fzm_next = fzm_reg;
    mode_next = mode_reg;
    zen_next = zen_reg;
    soft_reset_pulse_trig_next = 1'b0;
    if (wr)
    begin
      case (acc_index)
        `DMCR_IDX_FZM: fzm_next = acc_wdata & `DMCR_FZM_MASK;
        `DMCR_IDX_MODE:
        begin
          mode_next = acc_wdata & `DMCR_MODE_MASK;
          soft_reset_pulse_trig_next = acc_wdata[`DMCR_MODE_SOFT_RESET_PULSE];
        end
        `DMCR_IDX_ZEN: zen_next = acc_wdata & `DMCR_ZEN_MASK;
        default: fzm_next = fzm_reg;
      endcase
    end
  end

  always @(posedge sys_clk)
  begin
    if (int_rst)
    begin
      fzm_reg <= `DMCR_FZM_RESET;
      mode_reg <= `DMCR_MODE_RESET;
      zen_reg <= `DMCR_ZEN_RESET;
    end
    else if (ce)
    begin
      fzm_reg <= fzm_next;
      mode_reg <= mode_next;
      zen_reg <= zen_next;
    end
  end

  // One reset pulse per soft reset write
  dmcr_pulse u_soft_reset_pulse
  (
    .sys_clk(sys_clk),
    .soft_reset_pulse(soft_reset_pulse),
    .ce(ce),
    .trig(soft_reset_pulse_trig_next),
    .pulse(system_reset_pulse)
  );

  // Zero flag generation per mode
  always @*
  begin
    lz_next = 1'b0;
    rz_next = 1'b0;
    if (one_bit_stream_mode)
    begin
      case (stream_zero_pattern)
        `DMCR_PAT_OFF:
        begin
          lz_next = 1'b0;
          rz_next = 1'b0;
        end
        `DMCR_PAT_EVEN:
        begin
          lz_next = left_even_det;
          rz_next = right_even_det;
        end
        default:
        begin
          lz_next = left_96_det;
          rz_next = right_96_det;
        end
      endcase
    end
    else if (linear_zero_flag_enable)
    begin
      lz_next = left_zero_det;
      rz_next = right_zero_det;
    end
  end

  // Input routing
  always @*
  begin
    l_sel = single_channel_mode_data_pin;
    r_sel = single_channel_mode_data_pin;
    if (one_bit_stream_mode || (filter_bypass && stereo_bypass_select))
    begin
      l_sel = left_stream_pin;
      r_sel = right_stream_pin;
    end
    if (single_channel_mode)
    begin
      l_sel = single_channel_mode_channel_pick ? r_sel : l_sel;
      r_sel = l_sel;
    end
  end

  // Readback mux
  always @*
  begin
    hit_next = 1'b1;
    rdata_next = 8'h00;
    case (acc_index)
      `DMCR_IDX_FZM: rdata_next = fzm_reg;
      `DMCR_IDX_MODE: rdata_next = mode_reg;
      `DMCR_IDX_ZEN: rdata_next = zen_reg;
      `DMCR_IDX_ZST: rdata_next = {6'h00, right_zero_pin, left_zero_pin};
      default: hit_next = 1'b0;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (int_rst)
    begin
      acc_rdata_reg <= 8'h00;
      acc_rvalid_reg <= 1'b0;
      acc_hit_reg <= 1'b0;
      acc_rw_bit_reg <= 1'b0;
      left_zero_pin <= 1'b0;
      right_zero_pin <= 1'b0;
      mute_bpz_reg <= 1'b0;
      left_data_reg <= 1'b0;
      right_data_reg <= 1'b0;
    end
    else if (ce)
    begin
      acc_rvalid_reg <= acc_valid & acc_read;
      acc_hit_reg <= acc_valid & hit_next;
      // Status index forces read mode
      acc_rw_bit_reg <= acc_read | (acc_index == `DMCR_IDX_ZST);
      if (acc_valid && acc_read)
        acc_rdata_reg <= rdata_next;
      left_zero_pin <= lz_next;
      right_zero_pin <= rz_next;
      mute_bpz_reg <= zero_hold_mute_enable & ~one_bit_stream_mode &
        left_zero_det & right_zero_det;
      left_data_reg <= mute_bpz_reg ? 1'b0 : l_sel;
      right_data_reg <= mute_bpz_reg ? 1'b0 : r_sel;
    end
  end
endmodule // dmcr_regs
`default_nettype wire

// ===== dmcr_consts.vh
`ifndef DMCR_CONSTS_VH
`define DMCR_CONSTS_VH
// Register indices (seven-bit)
`define DMCR_IDX_FZM 7'h13
`define DMCR_IDX_MODE 7'h14
`define DMCR_IDX_ZEN 7'h15
`define DMCR_IDX_ZST 7'h16
// Filter and zero mute register fields
`define DMCR_FZM_HOLD 0
`define DMCR_FZM_ROLL 1
`define DMCR_FZM_STEREO 2
`define DMCR_FZM_MASK 8'h07
`define DMCR_FZM_RESET 8'h00
// Mode select register fields
`define DMCR_MODE_RATE_LO 0
`define DMCR_MODE_RATE_HI 1
`define DMCR_MODE_PICK 2
`define DMCR_MODE_SINGLE_CHANNEL_MODE 3
`define DMCR_MODE_BYPASS 4
`define DMCR_MODE_STREAM 5
`define DMCR_MODE_SOFT_RESET_PULSE 6
`define DMCR_MODE_MASK 8'h3f
`define DMCR_MODE_RESET 8'h00
// Zero flag enable register fields
`define DMCR_ZEN_LIN 0
`define DMCR_ZEN_PAT_LO 1
`define DMCR_ZEN_PAT_HI 2
`define DMCR_ZEN_MASK 8'h07
`define DMCR_ZEN_RESET 8'h01
// Modulator rate codes
`define DMCR_RATE_64 2'h0
`define DMCR_RATE_32 2'h1
`define DMCR_RATE_128 2'h2
`define DMCR_RATE_RSV 2'h3
// Stream zero pattern codes
`define DMCR_PAT_OFF 2'h0
`define DMCR_PAT_EVEN 2'h1
// Soft reset pulse length in cycles
`define DMCR_SOFT_RESET_PULSE_CYCLES 4'h1
`endif

// ===== dmcr_pulse.v
`timescale 1ns/1ps
`default_nettype none
module dmcr_pulse
(
  input wire sys_clk,
  input wire soft_reset_pulse,
  input wire ce,
  input wire trig,
  output reg pulse
);
  always @(posedge sys_clk)
  begin
    if (soft_reset_pulse)
      pulse <= 1'b0;
    else if (ce)
      pulse <= trig;
  end
endmodule // dmcr_pulse
`default_nettype wire

// ===== dmcr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dmcr_regs_assertions
(
  input wire logic sys_clk,
  input wire logic soft_reset_pulse,
  input wire logic ce,
  input wire logic acc_valid,
  input wire logic acc_read,
  input wire logic [6:0] acc_index,
  input wire logic [7:0] acc_rdata_reg,
  input wire logic acc_rvalid_reg,
  input wire logic acc_hit_reg,
  input wire logic acc_rw_bit_reg,
  input wire logic left_zero_det,
  input wire logic right_zero_det,
  input wire logic left_zero_pin,
  input wire logic mute_bpz_reg,
  input wire logic rolloff_select,
  input wire logic one_bit_stream_mode,
  input wire logic linear_zero_flag_enable,
  input wire logic system_reset_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (soft_reset_pulse);
  a_read_answer: assert property (ce && acc_valid && acc_read |=> acc_rvalid_reg)
    else $error("read not answered");
  a_index_decode: assert property (ce && acc_valid |=>
    acc_hit_reg == ($past(acc_index) >= 7'h13 && $past(acc_index) <= 7'h16)) else $error("bad hit");
  a_status_rbit: assert property (ce && acc_valid && acc_index == 7'h16 |=> acc_rw_bit_reg)
    else $error("status rw bit low");
  a_mode_reserved: assert property (ce && acc_valid && acc_read && acc_index == 7'h14
    |=> acc_rdata_reg[7:6] == 2'h0) else $error("mode high bits set");
  a_stream_nomute: assert property (one_bit_stream_mode && $past(one_bit_stream_mode)
    |-> !mute_bpz_reg) else $error("mute in stream mode");
  a_mute_cause: assert property (mute_bpz_reg |-> $past(left_zero_det && right_zero_det)
    || $past(left_zero_det && right_zero_det, 2)) else $error("mute without zero");
  a_flag_follow: assert property (!$past(soft_reset_pulse) && !$past(system_reset_pulse) &&
    $past(linear_zero_flag_enable && !one_bit_stream_mode) |-> left_zero_pin == $past(left_zero_det))
    else $error("zero pin wrong");
  a_soft_reset: assert property (system_reset_pulse |=> !system_reset_pulse &&
    linear_zero_flag_enable && !rolloff_select && !one_bit_stream_mode) else $error("soft reset");
  cover property (mute_bpz_reg);
  cover property (system_reset_pulse);
  cover property (acc_rvalid_reg && acc_hit_reg);
endmodule // dmcr_regs_assertions
`default_nettype wire

// ===== dmcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dmcr_host
(
  input wire logic sys_clk,
  output logic acc_valid = 1'b0,
  output logic acc_read = 1'b0,
  output logic [6:0] acc_index = 7'h00,
  output logic [7:0] acc_wdata = 8'h00
);
  // Held until the taking edge, then released with index and data inverted
  task automatic access(input logic rd, input logic [6:0] idx, input logic [7:0] wd);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_read <= rd;
    acc_index <= idx;
    acc_wdata <= wd;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    acc_index <= ~idx;
    acc_wdata <= ~wd;
    #1;
  endtask
endmodule // dmcr_host
`default_nettype wire

// ===== tb_dmcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dmcr_regs;
  logic sys_clk = 1'b0, soft_reset_pulse = 1'b1, ce = 1'b1, rnd = 1'b0, acc_valid, acc_read;
  logic left_zero_det = 1'b0, right_zero_det = 1'b0, left_even_det = 1'b0, right_even_det = 1'b0;
  logic left_96_det = 1'b0, right_96_det = 1'b0;
  logic single_channel_mode_data_pin = 1'b0, left_stream_pin = 1'b0, right_stream_pin = 1'b0;
  logic [6:0] acc_index, idx;
  logic [7:0] acc_wdata, wd;
  wire [7:0] acc_rdata_reg;
  wire acc_rvalid_reg, acc_hit_reg, acc_rw_bit_reg, left_data_reg, right_data_reg, left_zero_pin;
  wire right_zero_pin, mute_bpz_reg, rolloff_select, filter_bypass, one_bit_stream_mode;
  wire single_channel_mode, single_channel_mode_channel_pick, linear_zero_flag_enable, system_reset_pulse;
  wire [1:0] modulator_rate_select, stream_bit_clock_select, stream_zero_pattern;
  int bad_count = 0;
  int total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    {single_channel_mode_data_pin, left_stream_pin, right_stream_pin} <= 3'($urandom);
    if (rnd)
      {left_zero_det, right_zero_det} <= 2'($urandom);
  end
  dmcr_regs i_dut (.*);
  dmcr_host i_host (.*);
  function automatic logic [7:0] msk(input logic [6:0] i);
    return i == 7'h14 ? 8'h3f : (i > 7'h15) ? 8'h00 : 8'h07;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] exp);
    i_host.access(1'b1, i, 8'h00);
    chk(acc_rdata_reg, exp);
    chk({6'h00, acc_rvalid_reg, acc_hit_reg}, {6'h00, 1'b1, i >= 7'h13 && i <= 7'h16});
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    results;
  end
  initial
  begin
    void'($urandom(20850));
    repeat (4) @(posedge sys_clk);
    soft_reset_pulse <= 1'b0;
    for (int i = 19; i < 24; i++) rd(7'(i), i == 21 ? 8'h01 : 8'h00);
    rnd = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      idx = 7'h13 + 7'(i % 3);
      wd = {8'($urandom) & 8'hbc} | 8'(i / 3 % 4);
      i_host.access(1'b0, idx, wd);
      rd(idx, wd & msk(idx));
      case (idx)
        7'h13: chk({7'h00, rolloff_select}, {7'h00, wd[1]});
        7'h14: chk({one_bit_stream_mode, filter_bypass, single_channel_mode, single_channel_mode_channel_pick,
          modulator_rate_select, stream_bit_clock_select},
          {wd[5:2], wd[5] ? 2'h0 : wd[1:0], wd[5] ? wd[1:0] : 2'h0});
        default: chk({5'h00, stream_zero_pattern, linear_zero_flag_enable}, wd & 8'h07);
      endcase
    end
    rnd = 1'b0;
    i_host.access(1'b0, 7'h14, 8'h00);
    i_host.access(1'b0, 7'h15, 8'h01);
    i_host.access(1'b0, 7'h13, 8'h01);
    {left_zero_det, right_zero_det} <= 2'h3;
    repeat (3) @(posedge sys_clk);
    #1 chk({6'h00, mute_bpz_reg, left_zero_pin}, 8'h03);
    rd(7'h16, 8'h03);
    i_host.access(1'b0, 7'h16, 8'h00);
    rd(7'h16, 8'h03);
    @(posedge sys_clk) ce <= 1'b0;
    i_host.access(1'b0, 7'h13, 8'h06);
    @(posedge sys_clk) ce <= 1'b1;
    rd(7'h13, 8'h01);
    i_host.access(1'b0, 7'h14, 8'h20);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h00, mute_bpz_reg}, 8'h00);
    i_host.access(1'b0, 7'h14, 8'h60);
    repeat (2) @(posedge sys_clk);
    rd(7'h14, 8'h00);
    rd(7'h13, 8'h00);
    rd(7'h15, 8'h01);
    results;
  end
endmodule // tb_dmcr_regs
bind dmcr_regs dmcr_regs_assertions i_chk (.*);
`default_nettype wire
